// >>> halfbridge_serial_ctrl_if_tb_top.sv
`timescale 1ns/100ps
`include "hbsc_defines.svh"

module halfbridge_serial_ctrl_if_tb_top;
	import hbsc_pkg::*;
	logic                     ref_clk, rstn, wr, rd, inhibit_n, temp_prewarn_in, undervoltage_in;
	logic                     overcurrent_shutdown_en, applied;
	logic [`HBSC_ADDR_W-1:0]  addr;
	hbsc_word_t               wdata, rdata, ctrl_word, ctrl2, st, rx, w, prev, d, stat_live;
	hbsc_sw_t                 overcurrent_in, open_load_in, switch_on;
	int                       n_fail = 0;
	int                       samples_checked = 0;
	int                       cycles = 0;
	int                       n_applied = 0;
	int                       k;
	hbsc_word_t               pats [3] = '{`HBSC_TEST_PAT_A, `HBSC_TEST_PAT_B, `HBSC_TEST_PAT_C};

	hbsc_if i_hbsc_if ();
	hbsc_if i_hbsc_if2 ();
	hbsc_host i_hbsc_host (.ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .link(i_hbsc_if.host));
	hbsc_device i_hbsc_device (.ref_clk(ref_clk), .rstn(rstn), .link(i_hbsc_if.device), .inhibit_n(inhibit_n),
		.temp_prewarn_in(temp_prewarn_in), .overcurrent_in(overcurrent_in), .open_load_in(open_load_in),
		.undervoltage_in(undervoltage_in), .switch_on(switch_on), .overcurrent_shutdown_en(overcurrent_shutdown_en),
		.ctrl_word(ctrl_word), .status_word(stat_live), .frame_applied(applied));
	// second device faces the bench directly so frames can be malformed on purpose
	hbsc_device i_hbsc_device_b (.ref_clk(ref_clk), .rstn(rstn), .link(i_hbsc_if2.device), .inhibit_n(inhibit_n),
		.temp_prewarn_in(temp_prewarn_in), .overcurrent_in(overcurrent_in), .open_load_in(open_load_in),
		.undervoltage_in(undervoltage_in), .switch_on(), .overcurrent_shutdown_en(), .ctrl_word(ctrl2),
		.status_word(), .frame_applied());
	hbsc_link_chk i_hbsc_link_chk (.ref_clk(ref_clk), .rstn(rstn), .select_n(i_hbsc_if.select_n),
		.serial_clk(i_hbsc_if.serial_clk), .serial_in(i_hbsc_if.serial_in), .serial_out(i_hbsc_if.serial_out),
		.serial_out_oe(i_hbsc_if.serial_out_oe), .serial_out_line(i_hbsc_if.serial_out_line));

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		cycles++;
		if (applied === 1'b1) n_applied++;
		if (cycles == 40000) begin
			n_fail++;
			summarize();
		end
	end

	task automatic summarize();
		if (n_fail == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic wreg(input logic [3:0] a, input hbsc_word_t v);
		@(posedge ref_clk);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge ref_clk);
		wr    <= 1'b0;
	endtask : wreg

	task automatic rreg(input logic [3:0] a, output hbsc_word_t v);
		@(posedge ref_clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge ref_clk);
		rd   <= 1'b0;
		#1 v = rdata;
	endtask : rreg

	// the pause lets busy rise before polling, so a stale done is not taken
	task automatic cmd(input hbsc_word_t c);
		int i;
		wreg(`HBSC_REG_CMD, c);
		repeat (2) @(posedge ref_clk);
		for (i = 0; i < 400; i++) begin
			rreg(`HBSC_REG_STAT, st);
			if (st[`HBSC_STAT_DONE] === 1'b1 && st[`HBSC_STAT_BUSY] === 1'b0)
				break;
		end
		check("done", 16'(st[`HBSC_STAT_DONE]), 16'h0001);
	endtask : cmd

	task automatic frame(input hbsc_word_t v);
		wreg(`HBSC_REG_TX, v);
		cmd(16'h0001);
		rreg(`HBSC_REG_RX, rx);
	endtask : frame

	// data in is wrong at the rise and right only by the fall
	task automatic send2(input hbsc_word_t v, input int n);
		int i;
		@(posedge ref_clk) i_hbsc_if2.select_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
		for (i = 0; i < n; i++) begin
			i_hbsc_if2.serial_in  <= ~v[i % 16];
			i_hbsc_if2.serial_clk <= 1'b1;
			repeat (2) @(posedge ref_clk);
			i_hbsc_if2.serial_in  <= v[i % 16];
			repeat (2) @(posedge ref_clk);
			// value settled a cycle ago, so reading it at the edge is race free
			d[i % 16] = i_hbsc_if2.serial_out_line;
			i_hbsc_if2.serial_clk <= 1'b0;
			repeat (4) @(posedge ref_clk);
		end
		i_hbsc_if2.select_n  <= 1'b1;
		i_hbsc_if2.serial_in <= 1'b0;
		repeat (8) @(posedge ref_clk);
	endtask : send2

	task automatic fault(input int b, input hbsc_word_t v);
		frame(v);
		{undervoltage_in, open_load_in[0], overcurrent_in[0]} <= 3'(1 << (b - 13));
		repeat (10) @(posedge ref_clk);
		check("live_flag", 16'(stat_live[b]), 16'h0001);
		{undervoltage_in, open_load_in[0], overcurrent_in[0]} <= 3'h0;
		repeat (10) @(posedge ref_clk);
		check("sw_after", 16'(switch_on), 16'(!(b == 13 && v[13])));
		frame(v);
		check("flag", 16'(rx[b]), 16'h0001);
		check("sw_stat", 16'(rx[1]), 16'(!(b == 13 && v[13])));
		frame(v | 16'h0001);
		frame(v);
		check("cleared", rx & 16'hE000, 16'h0000);
		check("sw_back", 16'(switch_on), 16'h0001);
	endtask : fault

	initial begin
		{rstn, addr, wdata, wr, rd, undervoltage_in, overcurrent_in, open_load_in} = '0;
		inhibit_n = 1'b1;
		temp_prewarn_in = 1'b1;
		i_hbsc_if2.select_n = 1'b1;
		i_hbsc_if2.serial_clk = 1'b0;
		i_hbsc_if2.serial_in = 1'b0;
		repeat (6) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		check("ctrl_rst", ctrl_word, 16'h2000);
		check("sw_rst", 16'(switch_on), 16'h0000);
		check("ocs_rst", 16'(overcurrent_shutdown_en), 16'h0001);
		check("oe_rst", 16'(i_hbsc_if.serial_out_oe), 16'h0000);
		check("stat_rst", stat_live, 16'h0001);
		send2(16'hFFFF, 8);
		check("short_frame", ctrl2, 16'h2000);
		send2(16'hFFFF, 17);
		check("long_frame", ctrl2, 16'h2000);
		send2(16'h2056, 16);
		check("ctrl_b", ctrl2, 16'h2056);
		check("status_b", d, 16'h0001);
		check("oe_b", 16'(i_hbsc_if2.serial_out_oe), 16'h0000);
		cmd(16'h0002);
		check("peek", 16'(st[`HBSC_STAT_WARM]), 16'h0001);
		check("peek_ctrl", ctrl_word, 16'h2000);
		temp_prewarn_in <= 1'b0;
		prev = 16'h2000;
		for (k = 0; k < 7; k++) begin
			w = (k < 6) ? (16'h2000 | (16'h0002 << k)) : 16'h2000;
			fork
				frame(w);
				begin
					repeat (200) @(posedge ref_clk);
					check("ctrl_hold", ctrl_word, prev);
				end
			join
			check("ctrl", ctrl_word, w);
			check("sw", 16'(switch_on), 16'(w[6:1]));
			check("live_sw", stat_live & 16'h007E, {9'h000, w[6:1], 1'b0});
			check("rx", rx & 16'hE07F, {9'h000, prev[6:1], 1'b0});
			prev = w;
		end
		fault(14, 16'h2002);
		fault(15, 16'h2002);
		fault(13, 16'h2002);
		fault(13, 16'h0002);
		check("ocs_off", 16'(overcurrent_shutdown_en), 16'h0000);
		foreach (pats[i]) begin
			wreg(`HBSC_REG_TX, pats[i]);
			cmd(16'h0001);
			check("refused", 16'(st[`HBSC_STAT_REJ]), 16'h0001);
			check("ctrl_kept", ctrl_word, 16'h0002);
		end
		rreg(`HBSC_REG_TX, st);
		check("tx_back", st, `HBSC_TEST_PAT_C);
		// both command bits: the peek wins, so the stored test pattern is never sent
		cmd(16'h0003);
		check("peek_wins", 16'(st[`HBSC_STAT_REJ]), 16'h0000);
		check("peek_tp", 16'(st[`HBSC_STAT_WARM]), 16'h0000);
		check("peek_ctrl2", ctrl_word, 16'h0002);
		check("applied", 16'(n_applied), 16'h0017);
		rreg(4'h2, st);
		check("unmapped", st, 16'h0000);
		inhibit_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		check("ctrl_inh", ctrl_word, 16'h2000);
		inhibit_n <= 1'b1;
		summarize();
	end
endmodule : halfbridge_serial_ctrl_if_tb_top

// >>> hbsc_defines.svh
`ifndef HBSC_DEFINES_SVH
`define HBSC_DEFINES_SVH

// frame and word layout
`define HBSC_WORD_W        16
`define HBSC_CNT_W         5
`define HBSC_NSW           6
`define HBSC_FRAME_BITS    5'h10

// control word fields
`define HBSC_CTL_CLR       0
`define HBSC_CTL_SW_LO     1
`define HBSC_CTL_OC_EN     13
`define HBSC_CTL_RESET     16'h2000

// status word fields
`define HBSC_ST_WARM       0
`define HBSC_ST_SW_LO      1
`define HBSC_ST_SHORT      13
`define HBSC_ST_OPEN       14
`define HBSC_ST_SUPPLY     15

// reserved control patterns that enter factory test modes
`define HBSC_TEST_PAT_A    16'hF800
`define HBSC_TEST_PAT_B    16'hE600
`define HBSC_TEST_PAT_C    16'hE180

// host register map (byte addresses)
`define HBSC_ADDR_W        4
`define HBSC_REG_TX        4'h0
`define HBSC_REG_CMD       4'h4
`define HBSC_REG_STAT      4'h8
`define HBSC_REG_RX        4'hC
`define HBSC_CMD_FRAME     0
`define HBSC_CMD_PEEK      1
`define HBSC_STAT_BUSY     0
`define HBSC_STAT_DONE     1
`define HBSC_STAT_REJ      2
`define HBSC_STAT_WARM     3

// link timing
`define HBSC_REF_HZ        50000000
`define HBSC_SCLK_MAX_HZ   2000000
`define HBSC_HALF_DIV      ((`HBSC_REF_HZ + 2 * `HBSC_SCLK_MAX_HZ - 1) / (2 * `HBSC_SCLK_MAX_HZ))
`define HBSC_DIV_W         8

`endif

// >>> hbsc_device.sv
// Added by the designer: strobed register access and the address map.
`timescale 1ns/100ps

`include "hbsc_defines.svh"

// How it works
// - select falling edge starts a new frame
// - serial input sampled on serial clock falling
// - control word arrives least significant bit first
// - control word applied only on select rising
// - data out released while select high
// - data out changes on serial clock rising
// - status word leaves least significant bit first
// - clear bit drops supply, open-load, short flags
// - control bits one to six drive switches
// - bit thirteen enables overcurrent shutdown
// - status bits one to six show switches
// - status bit zero mirrors temperature prewarning
// - status bit thirteen flags a short, shutdown enabled or not
// - status bit fourteen flags open load
// - status bit fifteen flags supply undervoltage
// - reset: shutdown enabled, clear and switches low
// - host avoids the three test patterns
// - exactly sixteen bits each way per frame
// - short frame changes neither register
module hbsc_device (
	// clock and reset
	input  wire logic               ref_clk,
	input  wire logic               rstn,
	// serial link
	hbsc_if.device                  link,
	// power stage and protection
	input  wire logic               inhibit_n,
	input  wire logic               temp_prewarn_in,
	input  wire hbsc_pkg::hbsc_sw_t overcurrent_in,
	input  wire hbsc_pkg::hbsc_sw_t open_load_in,
	input  wire logic               undervoltage_in,
	// switch drive and register view
	output hbsc_pkg::hbsc_sw_t      switch_on,
	output logic                    overcurrent_shutdown_en,
	output hbsc_pkg::hbsc_word_t    ctrl_word,
	output hbsc_pkg::hbsc_word_t    status_word,
	output logic                    frame_applied
);
	import hbsc_pkg::*;

	hbsc_dev_state_t st_r;
	hbsc_dev_state_t st_nxt;

	logic [2:0] pins_s;
	logic       sel_s;
	logic       clk_s;
	logic       din_s;

	// idle link: select high, clock and data low
	hbsc_sync #(
		.W    (3),
		.INIT (3'h4)
	) u_pin_sync (
		.ref_clk  (ref_clk),
		.rstn     (rstn),
		.async_in ({link.select_n, link.serial_clk, link.serial_in}),
		.sync_out (pins_s)
	);

	assign sel_s = pins_s[2];
	assign clk_s = pins_s[1];
	assign din_s = pins_s[0];

	function automatic hbsc_dev_state_t reset_state();
		hbsc_dev_state_t s;
		s         = '0;
		s.sel_d   = 1'b1;
		s.ctrl    = `HBSC_CTL_RESET;
		s.status  = '0;
		return s;
	endfunction : reset_state

	function automatic hbsc_sw_t ctl_switches(input hbsc_word_t w);
		return w[`HBSC_CTL_SW_LO +: `HBSC_NSW];
	endfunction : ctl_switches

	function automatic hbsc_word_t pack_status(input logic warm, input hbsc_sw_t sw,
	                                           input logic shorted, input logic open_ld, input logic low_supply);
		hbsc_word_t w;
		w                              = '0;
		w[`HBSC_ST_WARM]               = warm;
		w[`HBSC_ST_SW_LO +: `HBSC_NSW] = sw;
		w[`HBSC_ST_SHORT]              = shorted;
		w[`HBSC_ST_OPEN]               = open_ld;
		w[`HBSC_ST_SUPPLY]             = low_supply;
		return w;
	endfunction : pack_status

	logic     sel_fall;
	logic     sel_rise;
	logic     sclk_fall;
	logic     sclk_rise;
	logic     apply;
	logic     clear;
	hbsc_sw_t short_ev;
	hbsc_sw_t open_ev;
	hbsc_sw_t cmd_sw;

	always_comb begin
		st_nxt    = st_r;
		sel_fall  = st_r.sel_d & ~sel_s;
		sel_rise  = ~st_r.sel_d & sel_s;
		sclk_fall = ~sel_s & st_r.clk_d & ~clk_s;
		sclk_rise = ~sel_s & ~st_r.clk_d & clk_s;
		apply     = 1'b0;
		clear     = 1'b0;
		short_ev  = overcurrent_in & st_r.sw_on;
		open_ev   = open_load_in & st_r.sw_on;
		cmd_sw    = '0;

		st_nxt.sel_d   = sel_s;
		st_nxt.clk_d   = clk_s;
		st_nxt.applied = 1'b0;

		// frame engine
		if (sel_fall) begin
			// freeze the status so the word read out is one coherent sample
			st_nxt.tx_sh  = st_r.status;
			st_nxt.do_bit = st_r.status[`HBSC_ST_WARM];
			st_nxt.out_en = 1'b1;
			st_nxt.cnt    = '0;
			st_nxt.rx_sh  = '0;
		end else if (sel_rise) begin
			st_nxt.out_en = 1'b0;
			// anything but exactly sixteen clocks is dropped, incl. a prewarning peek
			apply = (st_r.cnt == `HBSC_FRAME_BITS);
		end else if (sclk_fall) begin
			// new bit enters at the top, so bit 0 ends up at the bottom
			st_nxt.rx_sh = {din_s, st_r.rx_sh[`HBSC_WORD_W-1:1]};
			if (st_r.cnt != '1) begin
				st_nxt.cnt = st_r.cnt + 1'b1;
			end
		end else if (sclk_rise && st_r.cnt != '0) begin
			// first rising edge of a frame keeps bit 0 on the line
			st_nxt.tx_sh  = {1'b0, st_r.tx_sh[`HBSC_WORD_W-1:1]};
			st_nxt.do_bit = st_r.tx_sh[1];
		end

		// apply the received control word only when select returns high
		if (apply) begin
			st_nxt.ctrl    = st_r.rx_sh;
			st_nxt.applied = 1'b1;
			clear          = st_r.rx_sh[`HBSC_CTL_CLR];
		end

		// latched faults: clear first, then new events so a set wins
		if (clear) begin
			st_nxt.short_detected     = 1'b0;
			st_nxt.open_load_detected = 1'b0;
			st_nxt.supply_fail        = 1'b0;
			st_nxt.tripped            = '0;
		end
		if (|short_ev) begin
			st_nxt.short_detected = 1'b1;
		end
		if (st_nxt.ctrl[`HBSC_CTL_OC_EN]) begin
			st_nxt.tripped = st_nxt.tripped | short_ev;
		end
		if (|open_ev) begin
			st_nxt.open_load_detected = 1'b1;
		end
		if (undervoltage_in) begin
			st_nxt.supply_fail = 1'b1;
		end

		// switch drive: command, minus tripped switches, all off in undervoltage
		cmd_sw = ctl_switches(st_nxt.ctrl);
		if (undervoltage_in) begin
			st_nxt.sw_on = '0;
		end else begin
			st_nxt.sw_on = cmd_sw & ~st_nxt.tripped;
		end

		// switch bits reflect real state; a clear changes them only by releasing tripped switches
		st_nxt.status = pack_status(temp_prewarn_in, st_nxt.sw_on,
		                            st_nxt.short_detected, st_nxt.open_load_detected, st_nxt.supply_fail);

		// standby acts as a power-on reset of all device state except the pin synchroniser
		if (!inhibit_n) begin
			st_nxt = reset_state();
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= reset_state();
		end else begin
			st_r <= st_nxt;
		end
	end

	assign link.serial_out          = st_r.do_bit;
	assign link.serial_out_oe       = st_r.out_en;
	assign switch_on                = st_r.sw_on;
	assign overcurrent_shutdown_en  = st_r.ctrl[`HBSC_CTL_OC_EN];
	assign ctrl_word                = st_r.ctrl;
	assign status_word              = st_r.status;
	assign frame_applied            = st_r.applied;
endmodule : hbsc_device

// >>> hbsc_host.sv
`timescale 1ns/100ps

`include "hbsc_defines.svh"

module hbsc_host #(
	parameter logic [`HBSC_DIV_W-1:0] HALF_DIV = `HBSC_DIV_W'(`HBSC_HALF_DIV)
) (
	// clock and reset
	input  wire logic                      ref_clk,
	input  wire logic                      rstn,
	// register port
	input  wire logic [`HBSC_ADDR_W-1:0]   addr,
	input  wire hbsc_pkg::hbsc_word_t      wdata,
	input  wire logic                      wr,
	input  wire logic                      rd,
	output hbsc_pkg::hbsc_word_t           rdata,
	// serial link
	hbsc_if.host                           link
);
	import hbsc_pkg::*;

	hbsc_host_state_t st_r;
	hbsc_host_state_t st_nxt;
	logic             dout_s;

	hbsc_sync #(
		.W    (1),
		.INIT (1'b0)
	) u_do_sync (
		.ref_clk  (ref_clk),
		.rstn     (rstn),
		.async_in (link.serial_out_line),
		.sync_out (dout_s)
	);

	function automatic logic is_test_pattern(input hbsc_word_t w);
		return (w == `HBSC_TEST_PAT_A) || (w == `HBSC_TEST_PAT_B) || (w == `HBSC_TEST_PAT_C);
	endfunction : is_test_pattern

	logic       div_end;
	logic       cmd_wr;
	hbsc_word_t stat;

	always_comb begin
		st_nxt  = st_r;
		div_end = (st_r.div == HALF_DIV - 1'b1);
		cmd_wr  = wr && addr == `HBSC_REG_CMD;
		stat    = '0;
		stat[`HBSC_STAT_BUSY] = st_r.fsm != HBSC_H_IDLE;
		stat[`HBSC_STAT_DONE] = st_r.done;
		stat[`HBSC_STAT_REJ]  = st_r.rej;
		stat[`HBSC_STAT_WARM] = st_r.temp_prewarning;

		st_nxt.div = div_end ? '0 : st_r.div + 1'b1;

		if (wr && addr == `HBSC_REG_TX) begin
			st_nxt.tx = wdata;
		end

		// read data stands in the cycle after the strobe only
		st_nxt.rdata = '0;
		if (rd) begin
			case (addr)
				`HBSC_REG_TX:   st_nxt.rdata = st_r.tx;
				`HBSC_REG_STAT: st_nxt.rdata = stat;
				`HBSC_REG_RX:   st_nxt.rdata = st_r.rx;
				default:        st_nxt.rdata = '0;
			endcase
		end

		case (st_r.fsm)
			HBSC_H_IDLE: begin
				if (cmd_wr && (wdata[`HBSC_CMD_FRAME] || wdata[`HBSC_CMD_PEEK])) begin
					st_nxt.done = 1'b0;
					st_nxt.rej  = 1'b0;
					st_nxt.peek = wdata[`HBSC_CMD_PEEK];
					if (!wdata[`HBSC_CMD_PEEK] && is_test_pattern(st_r.tx)) begin
						st_nxt.rej  = 1'b1;
						st_nxt.done = 1'b1;
					end else begin
						st_nxt.fsm     = HBSC_H_LEAD;
						st_nxt.div     = '0;
						st_nxt.sel_n   = 1'b0;
						st_nxt.sh      = st_r.tx;
						st_nxt.sdi     = st_r.tx[0];
						st_nxt.bit_idx = '0;
						st_nxt.rx      = '0;
					end
				end
			end
			HBSC_H_LEAD: begin
				// two half periods give the device time to drive bit 0
				if (div_end && st_r.bit_idx != '0) begin
					st_nxt.bit_idx = '0;
					if (st_r.peek) begin
						st_nxt.temp_prewarning = dout_s;
						st_nxt.fsm = HBSC_H_TRAIL;
					end else begin
						st_nxt.fsm = HBSC_H_LOW;
					end
				end else if (div_end) begin
					st_nxt.bit_idx = 5'h01;
				end
			end
			HBSC_H_LOW: begin
				if (div_end) begin
					// data changes with the rising edge, well before the falling sample
					st_nxt.sclk = 1'b1;
					st_nxt.sdi  = st_r.sh[0];
					st_nxt.fsm  = HBSC_H_HIGH;
				end
			end
			HBSC_H_HIGH: begin
				if (div_end) begin
					st_nxt.sclk    = 1'b0;
					st_nxt.rx      = {dout_s, st_r.rx[`HBSC_WORD_W-1:1]};
					st_nxt.sh      = {1'b0, st_r.sh[`HBSC_WORD_W-1:1]};
					st_nxt.bit_idx = st_r.bit_idx + 1'b1;
					if (st_r.bit_idx == `HBSC_FRAME_BITS - 1'b1) begin
						st_nxt.fsm = HBSC_H_TRAIL;
					end else begin
						st_nxt.fsm = HBSC_H_LOW;
					end
				end
			end
			HBSC_H_TRAIL: begin
				if (div_end) begin
					st_nxt.sel_n   = 1'b1;
					st_nxt.bit_idx = '0;
					st_nxt.fsm     = HBSC_H_GAP;
				end
			end
			HBSC_H_GAP: begin
				if (div_end && st_r.bit_idx != '0) begin
					st_nxt.done = 1'b1;
					st_nxt.fsm  = HBSC_H_IDLE;
				end else if (div_end) begin
					st_nxt.bit_idx = 5'h01;
				end
			end
			default: begin
				st_nxt.fsm   = HBSC_H_IDLE;
				st_nxt.sel_n = 1'b1;
				st_nxt.sclk  = 1'b0;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_r       <= '0;
			st_r.fsm   <= HBSC_H_IDLE;
			st_r.sel_n <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign link.select_n   = st_r.sel_n;
	assign link.serial_clk = st_r.sclk;
	assign link.serial_in  = st_r.sdi;
	assign rdata           = st_r.rdata;
endmodule : hbsc_host

// >>> hbsc_if.sv
`timescale 1ns/100ps

interface hbsc_if;
	logic select_n;
	logic serial_clk;
	logic serial_in;
	logic serial_out;
	logic serial_out_oe;
	logic serial_out_line;

	// released line reads low, like a pulled-down shared data-out net
	assign serial_out_line = serial_out_oe & serial_out;

	modport host (
		output select_n,
		output serial_clk,
		output serial_in,
		input  serial_out_line
	);

	modport device (
		input  select_n,
		input  serial_clk,
		input  serial_in,
		output serial_out,
		output serial_out_oe
	);
endinterface : hbsc_if

// >>> hbsc_link_chk.sv
`timescale 1ns/100ps

module hbsc_link_chk (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// serial link
	input wire logic select_n,
	input wire logic serial_clk,
	input wire logic serial_in,
	input wire logic serial_out,
	input wire logic serial_out_oe,
	input wire logic serial_out_line
);
	logic       clk_q;
	logic [3:0] age;
	logic [4:0] rises;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	// age saturates so a long idle never wraps back into the legal window
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			clk_q <= 1'b0;
			age   <= 4'hF;
			rises <= 5'h00;
		end else begin
			clk_q <= serial_clk;
			age   <= (serial_clk & !clk_q) ? 4'h1 : ((age == 4'hF) ? age : age + 4'h1);
			rises <= select_n ? 5'h00 : rises + 5'(serial_clk & !clk_q);
		end
	end

	sequence s_frame_start;
		$fell(select_n);
	endsequence
	sequence s_lead_quiet;
		(!select_n && !serial_clk) [*8];
	endsequence
	sequence s_lead_held;
		$stable(serial_out_line) [*8];
	endsequence

	chk_oe_on_fall: assert property (s_frame_start |-> ##[1:4] serial_out_oe)
		else $error("data out not enabled after select fall");
	chk_lead_quiet: assert property (s_frame_start |-> s_lead_quiet)
		else $error("link clock moved too soon after select fall");
	chk_bit0_held: assert property (s_frame_start ##4 1'h1 |-> s_lead_held)
		else $error("data out moved before the first clock rise");
	chk_oe_off_idle: assert property (select_n [*5] |-> !serial_out_oe)
		else $error("data out driven while deselected");
	chk_do_on_rise: assert property ($changed(serial_out) && serial_out_oe && $past(serial_out_oe) |-> age inside {[4'h1:4'h8]})
		else $error("data out changed away from a clock rise");
	chk_frame_bits: assert property ($rose(select_n) |-> rises == 5'h10 || rises == 5'h00)
		else $error("frame ended with a wrong clock count");
	chk_clk_idle: assert property (select_n && $past(select_n) |-> !serial_clk)
		else $error("link clock running outside a frame");
	chk_din_moves: assert property ($changed(serial_in) |-> $rose(serial_clk) || $fell(select_n) || select_n)
		else $error("data in changed away from a clock rise");
	chk_clk_high: assert property ($rose(serial_clk) |-> serial_clk [*4])
		else $error("link clock high phase too short");
	chk_clk_low: assert property ($fell(serial_clk) && !select_n |-> !serial_clk [*4])
		else $error("link clock low phase too short");
endmodule : hbsc_link_chk

// >>> hbsc_pkg.sv
`include "hbsc_defines.svh"

package hbsc_pkg;

	typedef logic [`HBSC_WORD_W-1:0] hbsc_word_t;
	typedef logic [`HBSC_NSW-1:0]    hbsc_sw_t;

	typedef struct packed {
		logic                  sel_d;
		logic                  clk_d;
		hbsc_word_t            rx_sh;
		hbsc_word_t            tx_sh;
		logic [`HBSC_CNT_W-1:0] cnt;
		logic                  out_en;
		logic                  do_bit;
		hbsc_word_t            ctrl;
		hbsc_sw_t              tripped;
		logic                  short_detected;
		logic                  open_load_detected;
		logic                  supply_fail;
		hbsc_sw_t              sw_on;
		hbsc_word_t            status;
		logic                  applied;
	} hbsc_dev_state_t;

	typedef enum logic [2:0] {
		HBSC_H_IDLE,
		HBSC_H_LEAD,
		HBSC_H_LOW,
		HBSC_H_HIGH,
		HBSC_H_TRAIL,
		HBSC_H_GAP
	} hbsc_host_fsm_t;

	typedef struct packed {
		hbsc_host_fsm_t         fsm;
		logic [`HBSC_DIV_W-1:0] div;
		logic [`HBSC_CNT_W-1:0] bit_idx;
		logic                   peek;
		hbsc_word_t             tx;
		hbsc_word_t             sh;
		hbsc_word_t             rx;
		logic                   sel_n;
		logic                   sclk;
		logic                   sdi;
		logic                   done;
		logic                   rej;
		logic                   temp_prewarning;
		hbsc_word_t             rdata;
	} hbsc_host_state_t;

endpackage : hbsc_pkg

// >>> hbsc_sync.sv
`timescale 1ns/100ps

module hbsc_sync #(
	parameter int          W   = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// clock and reset
	input  wire logic         ref_clk,
	input  wire logic         rstn,
	// asynchronous in, synchronised out
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} hbsc_sync_state_t;

	hbsc_sync_state_t st_r;
	hbsc_sync_state_t st_nxt;

	always_comb begin
		st_nxt.meta = async_in;
		st_nxt.sync = st_r.meta;
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= {INIT, INIT};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign sync_out = st_r.sync;
endmodule : hbsc_sync
